// ==== core/cond_exec_cfg.svh ====
// Timing counts, type codes and address steps for the condition-gating block.
// Assumes inclusion by bare name from every file that needs these figures.
`ifndef COND_EXEC_CFG_SVH
`define COND_EXEC_CFG_SVH

// Instruction type codes carrying branch forms
`define TYPE_DIRECT_BRANCH   4'h8
`define TYPE_INDIRECT_FIRST  4'h9
`define TYPE_INDIRECT_REUSED 4'ha
`define TYPE_INDIRECT_LAST   4'hb

// Address step per word space
`define STEP_NORMAL_WORD 32'h0000_0001
`define STEP_SHORT_WORD  32'h0000_0002
`define STEP_BYTE_WORD   32'h0000_0004

// Stall lengths in core cycles
`define STALL_FETCH_CONFLICT   3'h1
`define STALL_CACHE_MISS       3'h1
`define STALL_BLOCK_CONFLICT   3'h1
`define STALL_STORE_TO_LOAD    3'h1
`define STALL_INDEX_LOAD       3'h4
`define STALL_INDEX_COND_LOAD  3'h5
`define STALL_DUAL_FORWARD     3'h2
`define STALL_WIDE_COMPUTE     3'h2

`endif

// ==== core/cond_exec_pkg.sv ====
// Types shared by the condition-gating block and its environment.
// Assumes the includer also pulls in cond_exec_cfg.svh for the figures.
package cond_exec_pkg;

  typedef enum logic [3:0] {
    mv_none,
    mv_pair_to_pair,
    mv_pair_to_unpaired,
    mv_unpaired_to_unpaired,
    mv_unpaired_to_pair,
    mv_store_primary,
    mv_store_secondary,
    mv_load_lanes,
    mv_load_address_generator
  } move_kind_t;

  typedef enum logic [2:0] {
    br_none,
    br_jump,
    br_call,
    br_return,
    br_loop,
    br_if_else
  } branch_kind_t;

  typedef enum logic [1:0] {
    normal_word_space,
    short_word_space,
    byte_word_space
  } word_space_t;

  typedef struct packed {
    logic         valid;
    logic         conditional;
    logic [3:0]   instr_type;
    logic         variable_length_isa;
    move_kind_t   move_kind;
    branch_kind_t branch_kind;
    word_space_t  space;
    logic         post_modify;
    logic         pre_modify;
    logic [31:0]  index_value;
    logic [31:0]  modify_value;
    logic [3:0]   index_sel;
    logic         uses_index;
    logic         loads_index;
    logic         is_load;
    logic         is_store;
    logic         program_memory_bus_data;
    logic         mul_dual_forward;
    logic         wide_compute;
  } instr_req_t;

  typedef struct packed {
    logic primary_lane;
    logic secondary_lane;
  } lane_cond_t;

  typedef struct packed {
    logic fetch_request;
    logic pm_cache_miss;
    logic block_conflict;
    logic interrupt_redirect;
    logic loop_abort;
  } hazard_in_t;

  typedef struct packed {
    logic        valid;
    logic        explicit_en;
    logic        implicit_en;
    logic        explicit_wide;
    logic        slot0_en;
    logic        slot0_from_secondary;
    logic        slot1_en;
    logic [31:0] slot0_addr;
    logic [31:0] slot1_addr;
    logic        index_write_en;
    logic [31:0] index_next;
    logic        branch_taken;
    logic        else_primary_en;
    logic        else_secondary_en;
    logic        branch_form;
    logic        reused_compute_form;
    logic        branch_rejected;
  } exec_ctrl_t;

endpackage : cond_exec_pkg

// ==== core/cond_exec_ctrl.sv ====
// Condition gating, branch decision and stall/flush control for two lanes.
// Assumes a decoder that holds a request stable while stall is high.
// Assumes hazard levels arrive with the request on the same clock.
// Stall is combinational; flush and ctrl are registered one cycle on.
// A withdrawn request drops any penalty charged to it.
// Operation
// - Paired-to-unpaired move: primary condition, explicit only.
// - Unpaired-to-unpaired move: explicit only, lane-tested.
// - Post-modify updates index on either lane true.
// - Each lane's transfer gated by own condition.
// - Pre-modify always applied to index.
// - Primary store: primary at index, secondary at index+n.
// - Secondary store: secondary at index, primary at index+n.
// - Address-generator load suppressed only if both false.
// - SIMD branch or loop needs both lanes true.
// - SIMD if-else: else runs per false lane.
// - Branch forms accepted in types 8 to 11; if-else only in types 9 to 11.
// - Variable-length type 10 decodes as compute.
// - Stall on fetch and data bus collision.
// - One-cycle stall on program bus cache miss.
// - One-cycle stall on same-block access collision.
// - One-cycle stall from conditional store to load.
// - Stall index use after index load.
// - Stall when both multiplier operands forwarded.
// - Stall wide compute to keep latency.
// - Flush fetched instructions on any redirect.
// - SISD tests only primary lane flags.
`timescale 1ns/100ps
`include "cond_exec_cfg.svh"

module cond_exec_ctrl
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Mode
  input  wire logic                      simd_mode,
  // Request from decode
  input  wire cond_exec_pkg::instr_req_t req,
  input  wire cond_exec_pkg::lane_cond_t cond,
  input  wire cond_exec_pkg::hazard_in_t hazard,
  // Pipeline control
  output logic                           stall,
  output logic                           flush,
  // Gated execution controls
  output cond_exec_pkg::exec_ctrl_t      ctrl
);

  // Lane step for the paired word of a store
  function automatic logic [31:0] space_step(input cond_exec_pkg::word_space_t sp);
    unique case (sp)
      cond_exec_pkg::normal_word_space: space_step = `STEP_NORMAL_WORD;
      cond_exec_pkg::short_word_space:  space_step = `STEP_SHORT_WORD;
      cond_exec_pkg::byte_word_space:   space_step = `STEP_BYTE_WORD;
      default:                          space_step = `STEP_NORMAL_WORD;
    endcase
  endfunction : space_step

  // Larger of two stall lengths
  function automatic logic [2:0] longer(input logic [2:0] a, input logic [2:0] b);
    longer = (a > b) ? a : b;
  endfunction : longer

  // Index moved by its modifier
  function automatic logic [31:0] modified_index(input logic [31:0] base,
                                                 input logic [31:0] step);
    modified_index = base + step;
  endfunction : modified_index

  logic       prim_ok;
  logic       sec_ok;
  logic       either_ok;
  logic       both_ok;
  logic       type_direct;
  logic       type_indirect;
  logic       reused_compute;
  logic       branch_legal;
  logic       taken;
  logic [2:0] penalty;
  logic       accept;
  logic [2:0] hold_count;
  logic       charged;
  logic       last_cond_store;
  logic       last_index_load;
  logic       last_index_cond;
  logic [3:0] last_index_sel;
  logic       taken_accepted;
  logic       branch_req;
  logic       if_else_legal;
  logic       store_hit;
  logic       index_hit;
  logic [2:0] index_wait;
  logic       charge;
  logic       redirect;
  cond_exec_pkg::exec_ctrl_t next_ctrl;

  // Lane condition outcomes
  always_comb
  begin
    if (!req.conditional)
    begin
      prim_ok = 1'b1;
      sec_ok  = 1'b1;
    end
    else
    begin
      prim_ok = cond.primary_lane;
      sec_ok  = simd_mode ? cond.secondary_lane : cond.primary_lane;
    end
  end

  assign either_ok = simd_mode ? (prim_ok | sec_ok) : prim_ok;
  assign both_ok   = simd_mode ? (prim_ok & sec_ok) : prim_ok;

  assign type_direct   = (req.instr_type == `TYPE_DIRECT_BRANCH);
  assign type_indirect = (req.instr_type == `TYPE_INDIRECT_FIRST)
                       | (req.instr_type == `TYPE_INDIRECT_REUSED)
                       | (req.instr_type == `TYPE_INDIRECT_LAST);
  assign reused_compute = req.variable_length_isa
                        & (req.instr_type == `TYPE_INDIRECT_REUSED);
  // Any branch form requested
  assign branch_req = (req.branch_kind != cond_exec_pkg::br_none);

  always_comb
  begin
    branch_legal = 1'b0;
    if (req.branch_kind == cond_exec_pkg::br_if_else)
      branch_legal = type_indirect & ~reused_compute;
    else if (branch_req)
      branch_legal = (type_direct | type_indirect) & ~reused_compute;
  end

  assign taken = branch_legal & both_ok;
  // else paths only on a legal if-else
  assign if_else_legal = (req.branch_kind == cond_exec_pkg::br_if_else) & branch_legal;

  assign store_hit  = req.is_load & last_cond_store;
  assign index_hit  = req.uses_index & last_index_load & (req.index_sel == last_index_sel);
  assign index_wait = last_index_cond ? `STALL_INDEX_COND_LOAD : `STALL_INDEX_LOAD;

  // Stall length demanded by the waiting request
  always_comb
  begin
    penalty = 3'h0;
    if (req.program_memory_bus_data && hazard.fetch_request)
      penalty = longer(penalty, `STALL_FETCH_CONFLICT);
    if (req.program_memory_bus_data && hazard.pm_cache_miss)
      penalty = longer(penalty, `STALL_CACHE_MISS);
    if (hazard.block_conflict)
      penalty = longer(penalty, `STALL_BLOCK_CONFLICT);
    if (store_hit)
      penalty = longer(penalty, `STALL_STORE_TO_LOAD);
    if (index_hit)
      penalty = longer(penalty, index_wait);
    if (req.mul_dual_forward)
      penalty = longer(penalty, `STALL_DUAL_FORWARD);
    if (req.wide_compute)
      penalty = longer(penalty, `STALL_WIDE_COMPUTE);
  end

  // Stall holds for exactly the penalty length
  assign stall  = req.valid & ((hold_count != 3'h0) | (~charged & (penalty != 3'h0)));
  assign accept = req.valid & ~stall;
  // Penalty charged on the first stalled cycle only
  assign charge = req.valid & ~charged & (penalty != 3'h0);

  // Stall counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_count <= 3'h0;
      charged    <= 1'b0;
    end
    else if (!req.valid)
    begin
      // Withdrawn request forgets its penalty
      hold_count <= 3'h0;
      charged    <= 1'b0;
    end
    else if (hold_count != 3'h0)
    begin
      hold_count <= hold_count - 3'h1;
    end
    else if (charge)
    begin
      hold_count <= penalty - 3'h1;
      charged    <= 1'b1;
    end
    else if (accept)
    begin
      charged <= 1'b0;
    end
  end

  // History of the last accepted instruction
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_cond_store <= 1'b0;
      last_index_load <= 1'b0;
      last_index_cond <= 1'b0;
      last_index_sel  <= 4'h0;
    end
    else if (accept)
    begin
      last_cond_store <= req.is_store & req.conditional;
      last_index_load <= req.loads_index;
      last_index_cond <= req.loads_index & req.conditional;
      last_index_sel  <= req.index_sel;
    end
    else if (charge)
    begin
      // Hazard already charged to the waiting request
      last_cond_store <= 1'b0;
      last_index_load <= 1'b0;
    end
  end

  // Transfer gating and addressing
  always_comb
  begin
    next_ctrl = '0;
    next_ctrl.valid = accept;
    next_ctrl.slot0_addr = req.index_value;
    if (req.pre_modify)
      next_ctrl.slot0_addr = modified_index(req.index_value, req.modify_value);
    // paired word at index plus n
    next_ctrl.slot1_addr = next_ctrl.slot0_addr + space_step(req.space);

    unique case (req.move_kind)
      cond_exec_pkg::mv_none:
      begin
        next_ctrl.explicit_en = 1'b0;
      end
      cond_exec_pkg::mv_pair_to_pair,
      cond_exec_pkg::mv_unpaired_to_pair,
      cond_exec_pkg::mv_load_lanes:
      begin
        // each lane on its own flag
        next_ctrl.explicit_en = prim_ok;
        next_ctrl.implicit_en = simd_mode & sec_ok;
      end
      cond_exec_pkg::mv_pair_to_unpaired:
      begin
        next_ctrl.explicit_en   = prim_ok;
        next_ctrl.explicit_wide = 1'b1;
      end
      cond_exec_pkg::mv_unpaired_to_unpaired:
      begin
        next_ctrl.explicit_en = either_ok;
      end
      cond_exec_pkg::mv_store_primary:
      begin
        next_ctrl.slot0_en = prim_ok;
        next_ctrl.slot1_en = simd_mode & sec_ok;
      end
      cond_exec_pkg::mv_store_secondary:
      begin
        next_ctrl.slot0_en             = prim_ok;
        next_ctrl.slot0_from_secondary = 1'b1;
        next_ctrl.slot1_en             = simd_mode & sec_ok;
      end
      cond_exec_pkg::mv_load_address_generator:
      begin
        next_ctrl.explicit_en = either_ok;
      end
      default:
      begin
        next_ctrl.explicit_en = 1'b0;
      end
    endcase

    next_ctrl.index_write_en = req.post_modify & either_ok;
    next_ctrl.index_next     = modified_index(req.index_value, req.modify_value);

    next_ctrl.branch_taken = taken;
    if (if_else_legal)
    begin
      next_ctrl.else_primary_en   = ~taken & ~prim_ok;
      next_ctrl.else_secondary_en = simd_mode & ~taken & ~sec_ok;
    end
    next_ctrl.branch_form         = branch_legal;
    next_ctrl.reused_compute_form = reused_compute;
    next_ctrl.branch_rejected     = branch_req & ~branch_legal;
  end

  // Registered controls, valid for one cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl <= '0;
    else if (accept)
      ctrl <= next_ctrl;
    else
      ctrl.valid <= 1'b0;
  end

  assign taken_accepted = accept & taken;

  assign redirect = taken_accepted | hazard.interrupt_redirect | hazard.loop_abort;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flush <= 1'b0;
    else
      flush <= redirect;
  end

endmodule : cond_exec_ctrl

// ==== tb/cond_exec_ctrl_props.sv ====
// Assertions on the condition-gating block ports.
// Assumes one clock and an async high reset.
`timescale 1ns/100ps
`include "cond_exec_cfg.svh"
module cond_exec_ctrl_props
(
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  // Watched ports
  input wire logic                      simd_mode,
  input wire cond_exec_pkg::instr_req_t req,
  input wire cond_exec_pkg::lane_cond_t cond,
  input wire cond_exec_pkg::hazard_in_t hazard,
  input wire logic                      stall,
  input wire logic                      flush,
  input wire cond_exec_pkg::exec_ctrl_t ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire        acc = req.valid & !stall;
  wire        p   = !req.conditional | cond.primary_lane;
  wire        s   = !req.conditional | (simd_mode ? cond.secondary_lane : cond.primary_lane);
  wire        ps  = p & s;
  wire        po  = p | s;
  wire        s1  = simd_mode & s;
  wire [3:0]  mk  = req.move_kind;
  wire [3:0]  ty  = req.instr_type;
  wire        br  = ty inside {[4'h8:4'hb]} && !(ty == 4'ha && req.variable_length_isa);
  wire [31:0] n   = req.space == cond_exec_pkg::byte_word_space ? `STEP_BYTE_WORD
    : req.space == cond_exec_pkg::short_word_space ? `STEP_SHORT_WORD : `STEP_NORMAL_WORD;
  wire [31:0] a0  = req.index_value + (req.pre_modify ? req.modify_value : 32'h0);

  wide_move_a: assert property (acc && mk == 4'h2
    |=> ctrl.explicit_en == $past(p) && !ctrl.implicit_en && ctrl.explicit_wide)
    else $error("paired to unpaired move gated wrongly");
  plain_move_a: assert property (acc && mk == 4'h3
    |=> ctrl.explicit_en == $past(po) && !ctrl.implicit_en)
    else $error("unpaired move gated wrongly");
  post_modify_a: assert property (acc && req.post_modify
    |=> ctrl.index_write_en == $past(po))
    else $error("post-modify write wrong");
  lane_store_a: assert property (acc && mk inside {4'h5, 4'h6}
    |=> ctrl.slot0_en == $past(p) && ctrl.slot1_en == $past(s1)
    && ctrl.slot1_addr == ctrl.slot0_addr + $past(n))
    else $error("store slots wrong");
  pre_modify_a: assert property (acc && mk inside {4'h5, 4'h6}
    |=> ctrl.slot0_addr == $past(a0))
    else $error("pre-modify address wrong");
  ag_load_a: assert property (acc && mk == 4'h8
    |=> ctrl.explicit_en == $past(po))
    else $error("address generator load gated wrongly");
  both_lanes_a: assert property (acc && br && req.branch_kind inside {[1:4]}
    |=> ctrl.branch_taken == $past(ps))
    else $error("branch decision wrong");
  else_lane_a: assert property (acc && br && ty != 4'h8 && req.branch_kind == 3'h5
    |=> ctrl.else_primary_en != $past(p)
    && ctrl.else_secondary_en == ($past(simd_mode) & !$past(s)))
    else $error("else lanes wrong");
  reused_form_a: assert property (acc && ty == 4'ha && req.variable_length_isa
    && req.branch_kind != 3'h0 |=> ctrl.reused_compute_form && !ctrl.branch_taken)
    else $error("reused opcode taken as branch");
  block_stall_a: assert property (!$past(stall) && req.valid
    && (hazard.block_conflict
    || req.program_memory_bus_data && (hazard.pm_cache_miss || hazard.fetch_request)) |-> stall)
    else $error("conflict did not stall");
  dual_stall_a: assert property (!$past(stall) && req.valid
    && (req.mul_dual_forward || req.wide_compute) |-> stall [*2])
    else $error("forward or wide stall short");
  redirect_flush_a: assert property (hazard.interrupt_redirect || hazard.loop_abort
    || acc && br && req.branch_kind != 3'h0 && ps
    && !(req.branch_kind == 3'h5 && ty == 4'h8) |=> flush)
    else $error("redirect without flush");
endmodule : cond_exec_ctrl_props

bind cond_exec_ctrl cond_exec_ctrl_props i_cond_exec_ctrl_props (.clk(clk), .rst(rst),
  .simd_mode(simd_mode), .req(req), .cond(cond), .hazard(hazard), .stall(stall),
  .flush(flush), .ctrl(ctrl));

// ==== tb/mem_dag_model.sv ====
// Memory and address generator side: raises conflicts.
// Assumes the core holds a stalled request unchanged.
`timescale 1ns/100ps
module mem_dag_model
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Core view
  input  wire logic                      req_valid,
  input  wire logic                      stall,
  input  wire cond_exec_pkg::hazard_in_t want,
  // Conflicts to the core
  output cond_exec_pkg::hazard_in_t      hazard
);
  logic                      hold;
  cond_exec_pkg::hazard_in_t held;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      hold <= 1'b0;
    else
      hold <= req_valid & stall;
  always_ff @(posedge clk)
    held <= hazard;
  assign hazard = hold ? {held[4:2], want[1:0]} : want;
endmodule : mem_dag_model

// ==== tb/cond_exec_ctrl_tb.sv ====
// Self-checking bench for the condition-gating block.
// Assumes the memory model feeds the hazard inputs.
`timescale 1ns/100ps
`include "cond_exec_cfg.svh"
module cond_exec_ctrl_tb;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      simd_mode = 1'b0;
  logic                      stall;
  logic                      flush;
  cond_exec_pkg::instr_req_t req = '0;
  cond_exec_pkg::instr_req_t r;
  cond_exec_pkg::lane_cond_t cond = '0;
  cond_exec_pkg::hazard_in_t want = '0;
  cond_exec_pkg::hazard_in_t h;
  cond_exec_pkg::hazard_in_t hazard;
  cond_exec_pkg::exec_ctrl_t ctrl;
  cond_exec_pkg::instr_req_t er;
  logic [106:0]              ev;
  cond_exec_pkg::exec_ctrl_t ee;
  logic [1:0]                eb;
  int                        stalls;
  int                        n_fail = 0;
  int                        num_checks = 0;
  int                        seed = 47;
  int                        cyc = 0;
  always #5 clk = ~clk;
  cond_exec_ctrl i_cond_exec_ctrl (.clk(clk), .rst(rst), .simd_mode(simd_mode),
    .req(req), .cond(cond), .hazard(hazard), .stall(stall), .flush(flush), .ctrl(ctrl));
  mem_dag_model i_mem_dag_model (.clk(clk), .rst(rst), .req_valid(req.valid),
    .stall(stall), .want(want), .hazard(hazard));

  function automatic logic [106:0] pick(cond_exec_pkg::exec_ctrl_t c,
    cond_exec_pkg::instr_req_t q);
    logic st;
    logic el;
    st = q.move_kind inside {4'h5, 4'h6};
    el = q.branch_kind == 3'h5 && q.instr_type inside {4'h9, 4'ha, 4'hb}
      && !(q.instr_type == 4'ha && q.variable_length_isa);
    return {(q.move_kind != 4'h0 && !st) ? {c.explicit_en, c.implicit_en, c.explicit_wide} : 3'h0,
      st ? {c.slot0_en, c.slot1_en, c.slot0_from_secondary, c.slot0_addr, c.slot1_addr} : 67'h0,
      c.index_write_en, (q.post_modify && !q.pre_modify && !q.conditional) ? c.index_next : 32'h0,
      c.branch_taken, el ? {c.else_primary_en, c.else_secondary_en} : 2'h0,
      q.branch_kind != 3'h0 ? c.reused_compute_form : 1'b0};
  endfunction : pick

  function automatic cond_exec_pkg::exec_ctrl_t expect_ctrl(cond_exec_pkg::instr_req_t q,
    cond_exec_pkg::lane_cond_t l, logic sm);
    cond_exec_pkg::exec_ctrl_t e;
    logic p;
    logic s;
    e = '0;
    p = !q.conditional | l.primary_lane;
    s = !q.conditional | (sm ? l.secondary_lane : l.primary_lane);
    case (q.move_kind)
      4'h1, 4'h4, 4'h7: {e.explicit_en, e.implicit_en} = {p, sm & s};
      4'h2: {e.explicit_en, e.explicit_wide} = {p, 1'b1};
      4'h5, 4'h6: {e.slot0_en, e.slot1_en, e.slot0_from_secondary}
        = {p, sm & s, q.move_kind[0] == 1'b0};
      default: e.explicit_en = p | s;
    endcase
    e.slot0_addr = q.index_value + (q.pre_modify ? q.modify_value : 32'h0);
    e.slot1_addr = e.slot0_addr + (q.space == 2'h0 ? `STEP_NORMAL_WORD
      : q.space == 2'h1 ? `STEP_SHORT_WORD : `STEP_BYTE_WORD);
    e.index_write_en = q.post_modify & (p | s);
    e.index_next = q.index_value + q.modify_value;
    e.reused_compute_form = q.instr_type == 4'ha && q.variable_length_isa;
    e.branch_form = q.branch_kind != 3'h0 && q.instr_type inside {[4'h8:4'hb]}
      && !e.reused_compute_form && !(q.branch_kind == 3'h5 && q.instr_type == 4'h8);
    e.branch_rejected = q.branch_kind != 3'h0 && !e.branch_form;
    e.branch_taken = e.branch_form & p & s;
    e.else_primary_en = !e.branch_taken & !p;
    e.else_secondary_en = sm & !e.branch_taken & !s;
    return e;
  endfunction : expect_ctrl

  task automatic check(input logic [106:0] got, input logic [106:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic issue(input cond_exec_pkg::instr_req_t q, input cond_exec_pkg::hazard_in_t hz,
    input int es);
    int k;
    k = 0;
    req <= q;
    want <= hz;
    cond <= 2'($random(seed));
    simd_mode <= 1'($random(seed));
    #1;
    while (stall === 1'b1 && k < 9)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(107'(k), 107'(es));
    @(posedge clk);
  endtask : issue

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  always @(posedge clk)
    if (!rst && req.valid === 1'b1 && stall === 1'b0)
    begin
      er = req;
      ee = expect_ctrl(req, cond, simd_mode);
      ev = pick(ee, req);
      eb = {ee.branch_form, ee.branch_rejected};
      #1;
      check({ctrl.valid, flush}, {1'b1, ev[3]});
      check(107'({ctrl.branch_form, ctrl.branch_rejected}), 107'(eb));
      check(pick(ctrl, er), ev);
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    r = '0;
    r.valid = 1'b1;
    r.conditional = 1'b1;
    r.is_store = 1'b1;
    issue(r, '0, 0);
    r.is_store = 1'b0;
    r.is_load = 1'b1;
    issue(r, '0, 1);
    for (int c = 0; c < 2; c++)
    begin
      r = '0;
      r.valid = 1'b1;
      r.conditional = 1'(c);
      r.loads_index = 1'b1;
      r.index_sel = 4'h3;
      issue(r, '0, 0);
      r = '0;
      r.valid = 1'b1;
      r.uses_index = 1'b1;
      r.index_sel = 4'h3;
      issue(r, '0, 4 + c);
    end
    r = '0;
    r.valid = 1'b1;
    r.mul_dual_forward = 1'b1;
    issue(r, '0, 2);
    {r.mul_dual_forward, r.wide_compute} = 2'h1;
    issue(r, '0, 2);
    repeat (80)
    begin
      r = '0;
      {r.conditional, r.variable_length_isa, r.post_modify, r.pre_modify} = 4'($random(seed));
      r.instr_type = 4'($random(seed));
      {r.index_value, r.modify_value} = {$random(seed), $random(seed)};
      r.move_kind = cond_exec_pkg::move_kind_t'($unsigned($random(seed)) % 9);
      r.branch_kind = cond_exec_pkg::branch_kind_t'($unsigned($random(seed)) % 6);
      r.space = cond_exec_pkg::word_space_t'($unsigned($random(seed)) % 3);
      {r.valid, r.program_memory_bus_data} = {1'b1, 1'($random(seed))};
      h = {3'($random(seed)), 2'h0};
      stalls = int'(h.block_conflict
        | r.program_memory_bus_data & (h.pm_cache_miss | h.fetch_request));
      issue(r, h, stalls);
    end
    req.valid <= 1'b0;
    want <= '0;
    for (int i = 1; i < 3; i++)
    begin
      @(posedge clk);
      want <= 5'(i);
      @(posedge clk);
      want <= '0;
      #1;
      check(107'(flush), 107'h1);
    end
    finish_test();
  end
endmodule : cond_exec_ctrl_tb
